// file: rtl/ctlc_params.svh
// constants and operation summary for the continuity tester limit command block
// Operation
// - resistance upper 0.001..1.200/0.600 ohm, three decimals
// - resistance limit command selects resistance judgment
// - upper below lower blocks start, warns
// - current times upper over 5.4 V blocks
// - over rated output blocks start, flags error
// - power overload in test trips protection, stops test
// - voltage upper 0.01..5.40 V, default 0.60
// - voltage limit command selects voltage judgment
// - voltage over current above 0.6 ohm blocks
// - offset cancel 0/1, default off
// - test time 0.3..999 s, timer flag
// - start begins test or advances held step
// - start only on main, offset, program screens
// - stop ends test, clears hold states
// - screens 0..4, query returns 5 otherwise
// - readings live in test, then last captured
// - max mode returns maximum of judged quantity
// - resistance monitor order, status bits 2,3
// - voltage monitor order: status, resistance, current...
// - time reports elapsed or remaining by timer
// - one shared judgment mode bit
`ifndef CTLC_PARAMS_SVH
`define CTLC_PARAMS_SVH
`define CTLC_RUP_MIN 16'h0001
`define CTLC_RUP_MAX_LO 16'h04B0
`define CTLC_RUP_MAX_HI 16'h0258
`define CTLC_RUP_DEF 16'h0001
`define CTLC_VUP_MIN 16'h0001
`define CTLC_VUP_MAX 16'h021C
`define CTLC_VUP_DEF 16'h003C
`define CTLC_TIME_MIN 16'h0003
`define CTLC_TIME_STEP_EDGE 16'h03E8
`define CTLC_TIME_MAX 16'h2706
`define CTLC_TIME_DEF 16'h000A
`define CTLC_VLIM_MV 32'h0000_1518
`define CTLC_RLIM_MOHM 32'h0000_0258
`define CTLC_SCR_OTHER 3'h5
`define CTLC_SCR_MAX 3'h4
`define CTLC_ST_TEST 2
`define CTLC_ST_TESTON 3
`define CTLC_TICK_NS 32'h05F5_E100
`define CTLC_CLK_NS 32'h0000_0064
`endif

// file: rtl/ctlc_pkg.sv
// types for the continuity tester limit command block
package ctlc_pkg;
  typedef enum logic [3:0] {
    CTLC_CMD_NONE, CTLC_CMD_RUP, CTLC_CMD_VUP, CTLC_CMD_OFFS, CTLC_CMD_TIME,
    CTLC_CMD_BEGIN, CTLC_CMD_STOP, CTLC_CMD_SCREEN, CTLC_CMD_RESISTANCE_JUDGMENT_SELECT, CTLC_CMD_VOLTAGE_JUDGMENT_SELECT
  } ctlc_cmd_e;
  typedef enum logic [2:0] {
    CTLC_Q_CUR, CTLC_Q_RES, CTLC_Q_VOLT, CTLC_Q_TIME, CTLC_Q_MON
  } ctlc_query_e;
  typedef struct packed {
    ctlc_cmd_e op;
    logic [15:0] value;
    logic flag;
  } ctlc_cmd_s;
  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] res;
    logic [15:0] volt;
    logic over_power;
  } ctlc_meas_s;
  typedef struct packed {
    logic [7:0] status;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] f3;
    logic [15:0] f4;
    logic [15:0] f5;
  } ctlc_mon_s;
endpackage

// file: rtl/ctlc_track.sv
// reading holder: live, last captured and maximum
`timescale 1ns/10ps
module ctlc_track #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic start_i,
  input wire logic [W-1:0] live_i,
  output logic [W-1:0] last_o,
  output logic [W-1:0] max_o
);
  logic [W-1:0] last_d;
  logic [W-1:0] max_d;
  assign last_d = run_i ? live_i : last_o;
  assign max_d = start_i ? '0 : (run_i && live_i > max_o) ? live_i : max_o;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      last_o <= '0;
      max_o <= '0;
    end else begin
      last_o <= last_d;
      max_o <= max_d;
    end
  end
endmodule

// file: rtl/ctlc_top.sv
// remote limit, timer and test control command interpreter
`timescale 1ns/10ps
`include "ctlc_params.svh"
module ctlc_top #(
  parameter bit HIGH_CURRENT = 1'b0,
  parameter int TICK_CYCLES = `CTLC_TICK_NS / `CTLC_CLK_NS,
  parameter logic [31:0] RATED_VA = 32'h0000_01F4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ctlc_pkg::ctlc_cmd_s cmd_i,
  input wire logic cmd_valid_i,
  input wire logic query_valid_i,
  input wire ctlc_pkg::ctlc_query_e query_i,
  input wire ctlc_pkg::ctlc_meas_s meas_i,
  input wire logic [15:0] test_current_i,
  input wire logic [15:0] lower_limit_i,
  input wire logic lower_enable_i,
  input wire logic max_mode_i,
  input wire logic prog_running_i,
  input wire logic prog_held_i,
  input wire logic [2:0] screen_live_i,
  output logic [15:0] rup_o,
  output logic [15:0] vup_o,
  output logic resist_judge_o,
  output logic offset_en_o,
  output logic [15:0] test_time_o,
  output logic timer_en_o,
  output logic testing_o,
  output logic protect_o,
  output logic step_advance_o,
  output logic cmd_reject_o,
  output logic limit_order_warn_o,
  output logic over_voltage_setting_error_o,
  output logic over_rating_setting_error_o,
  output logic over_resistance_setting_error_o,
  output logic [2:0] screen_o,
  output logic [15:0] reading_o,
  output ctlc_pkg::ctlc_mon_s monitor_o,
  output logic answer_valid_o
);
  // ==========================================================
  // input synchronisers for pin-side signals
  ctlc_pkg::ctlc_meas_s meas_m, meas_s;
  logic over_power_s;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meas_m <= '0;
      meas_s <= '0;
    end else begin
      meas_m <= meas_i;
      meas_s <= meas_m;
    end
  end
  assign over_power_s = meas_s.over_power;

  // ==========================================================
  // command decode and range checks
  logic is_rup, is_vup, is_offs, is_time, is_begin, is_stop, is_scr;
  logic is_resistance_judgment_select, is_voltage_judgment_select;
  logic [15:0] rup_max;
  logic rup_ok, vup_ok, time_ok, scr_ok;
  assign is_rup = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_RUP;
  assign is_vup = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_VUP;
  assign is_offs = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_OFFS;
  assign is_time = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_TIME;
  assign is_begin = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_BEGIN;
  assign is_stop = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_STOP;
  assign is_scr = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_SCREEN;
  assign is_resistance_judgment_select = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_RESISTANCE_JUDGMENT_SELECT;
  assign is_voltage_judgment_select = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_VOLTAGE_JUDGMENT_SELECT;
  assign rup_max = HIGH_CURRENT ? `CTLC_RUP_MAX_HI : `CTLC_RUP_MAX_LO;
  assign rup_ok = cmd_i.value >= `CTLC_RUP_MIN && cmd_i.value <= rup_max;
  assign vup_ok = cmd_i.value >= `CTLC_VUP_MIN && cmd_i.value <= `CTLC_VUP_MAX;
  // time in 0.1 s units; whole seconds required from 100 s
  assign time_ok = cmd_i.value >= `CTLC_TIME_MIN && cmd_i.value <= `CTLC_TIME_MAX
    && (cmd_i.value < `CTLC_TIME_STEP_EDGE || cmd_i.value % 16'h000A == 16'h0000);
  assign scr_ok = cmd_i.value[15:3] == 13'h0000 && cmd_i.value[2:0] <= `CTLC_SCR_MAX;

  // ==========================================================
  // setting registers
  logic [15:0] rup_d, vup_d, time_d;
  logic judge_d, offs_d, timer_d, reject_d;
  logic [2:0] scr_d;
  assign rup_d = (is_rup && rup_ok) ? cmd_i.value : rup_o;
  assign vup_d = (is_vup && vup_ok) ? cmd_i.value : vup_o;
  assign time_d = (is_time && time_ok) ? cmd_i.value : test_time_o;
  assign timer_d = (is_time && time_ok) ? cmd_i.flag : timer_en_o;
  assign offs_d = is_offs ? cmd_i.flag : offset_en_o;
  // one shared bit: 1 = resistance judgment
  assign judge_d = (is_rup && rup_ok) ? 1'b1 :
    (is_vup && vup_ok) ? 1'b0 :
    is_resistance_judgment_select ? cmd_i.flag : is_voltage_judgment_select ? ~cmd_i.flag : resist_judge_o;
  assign scr_d = (is_scr && scr_ok) ? cmd_i.value[2:0] :
    (screen_live_i > `CTLC_SCR_MAX) ? `CTLC_SCR_OTHER : screen_live_i;
  assign reject_d = (is_rup && !rup_ok) || (is_vup && !vup_ok) || (is_time && !time_ok)
    || (is_scr && !scr_ok);

  // ==========================================================
  // setting checks that block a start
  logic [31:0] volt_prod, res_prod, va_prod;
  logic order_bad, ov_bad, or_bad, va_bad, blocked;
  // current in 0.1 A, limit in mohm: product /10 gives mV
  assign volt_prod = 32'(test_current_i) * 32'(rup_o);
  // limit in 10 mV, current in 0.1 A: mohm = vup*100 / cur
  assign res_prod = 32'(vup_o) * 32'h0000_0064;
  assign order_bad = lower_enable_i && rup_o < lower_limit_i;
  assign ov_bad = resist_judge_o
    && volt_prod > `CTLC_VLIM_MV * 32'h0000_000A;
  assign or_bad = !resist_judge_o
    && res_prod > `CTLC_RLIM_MOHM * 32'(test_current_i);
  // rated power: current times limit voltage, both modes in 10 mV units
  logic [47:0] va_wide;
  assign va_wide = resist_judge_o ? 48'(volt_prod / 32'h0000_0064) * 48'(test_current_i) :
    48'(test_current_i) * 48'(vup_o);
  assign va_prod = 32'(va_wide / 48'h0000_0000_03E8);
  assign va_bad = va_prod > RATED_VA;
  assign blocked = order_bad || ov_bad || or_bad || va_bad;

  // ==========================================================
  // test control
  logic scr_start_ok, go, adv, run_d, prot_d;
  assign scr_start_ok = screen_o == 3'h0 || screen_o == 3'h1 || screen_o == 3'h4;
  assign adv = is_begin && scr_start_ok && prog_running_i && prog_held_i;
  assign go = is_begin && scr_start_ok && !adv && !blocked && !testing_o && !protect_o;
  logic done;
  assign run_d = is_stop ? 1'b0 : go ? 1'b1 : (over_power_s || done) ? 1'b0 : testing_o;
  assign prot_d = (testing_o && over_power_s) ? 1'b1 : is_stop ? 1'b0 : protect_o;

  // ==========================================================
  // test timer in 0.1 s ticks
  logic [31:0] tick_q, tick_d;
  logic [15:0] elapsed_q, elapsed_d, remain;
  logic tick;
  assign tick = tick_q == 32'(TICK_CYCLES - 1);
  assign tick_d = (!testing_o || tick) ? 32'h0 : tick_q + 32'h1;
  assign elapsed_d = go ? 16'h0000 : (testing_o && tick) ? elapsed_q + 16'h0001 : elapsed_q;
  assign done = timer_en_o && testing_o && tick && elapsed_d >= test_time_o;
  assign remain = test_time_o > elapsed_q ? test_time_o - elapsed_q : 16'h0000;

  // ==========================================================
  // reading holders
  logic [15:0] cur_l, res_l, volt_l, res_m, volt_m, cur_m;
  ctlc_track #(.W(16)) u_cur (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(testing_o),
    .start_i(go), .live_i(meas_s.cur), .last_o(cur_l), .max_o(cur_m));
  ctlc_track #(.W(16)) u_res (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(testing_o),
    .start_i(go), .live_i(meas_s.res), .last_o(res_l), .max_o(res_m));
  ctlc_track #(.W(16)) u_volt (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(testing_o),
    .start_i(go), .live_i(meas_s.volt), .last_o(volt_l), .max_o(volt_m));

  // ==========================================================
  // query answers
  logic [15:0] res_now, volt_now, time_now, read_d;
  logic [7:0] status;
  ctlc_pkg::ctlc_mon_s mon_d;
  assign res_now = testing_o ? meas_s.res : res_l;
  assign volt_now = testing_o ? meas_s.volt : volt_l;
  assign time_now = timer_en_o ? remain : elapsed_q;
  always_comb begin
    status = 8'h00;
    status[`CTLC_ST_TEST] = testing_o;
    status[`CTLC_ST_TESTON] = testing_o;
  end
  always_comb begin
    unique case (query_i)
      ctlc_pkg::CTLC_Q_CUR: read_d = testing_o ? meas_s.cur : cur_l;
      ctlc_pkg::CTLC_Q_RES: read_d = (max_mode_i && resist_judge_o) ? res_m : res_now;
      ctlc_pkg::CTLC_Q_VOLT: read_d = (max_mode_i && !resist_judge_o) ? volt_m : volt_now;
      ctlc_pkg::CTLC_Q_TIME: read_d = time_now;
      default: read_d = 16'h0000;
    endcase
  end
  always_comb begin
    mon_d.status = status;
    mon_d.f2 = testing_o ? meas_s.cur : cur_l;
    mon_d.f5 = time_now;
    if (resist_judge_o) begin
      mon_d.f1 = volt_now;
      mon_d.f3 = res_m;
      mon_d.f4 = res_now;
    end else begin
      mon_d.f1 = res_now;
      mon_d.f3 = volt_m;
      mon_d.f4 = volt_now;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rup_o <= `CTLC_RUP_DEF;
      vup_o <= `CTLC_VUP_DEF;
      test_time_o <= `CTLC_TIME_DEF;
      timer_en_o <= 1'b0;
      offset_en_o <= 1'b0;
      resist_judge_o <= 1'b1;
      screen_o <= 3'h0;
      cmd_reject_o <= 1'b0;
      testing_o <= 1'b0;
      protect_o <= 1'b0;
      step_advance_o <= 1'b0;
      limit_order_warn_o <= 1'b0;
      over_voltage_setting_error_o <= 1'b0;
      over_rating_setting_error_o <= 1'b0;
      over_resistance_setting_error_o <= 1'b0;
      tick_q <= 32'h0;
      elapsed_q <= 16'h0000;
      reading_o <= 16'h0000;
      monitor_o <= '0;
      answer_valid_o <= 1'b0;
    end else begin
      rup_o <= rup_d;
      vup_o <= vup_d;
      test_time_o <= time_d;
      timer_en_o <= timer_d;
      offset_en_o <= offs_d;
      resist_judge_o <= judge_d;
      screen_o <= scr_d;
      cmd_reject_o <= reject_d;
      testing_o <= run_d;
      protect_o <= prot_d;
      step_advance_o <= adv;
      limit_order_warn_o <= order_bad;
      over_voltage_setting_error_o <= ov_bad;
      over_rating_setting_error_o <= va_bad;
      over_resistance_setting_error_o <= or_bad;
      tick_q <= tick_d;
      elapsed_q <= elapsed_d;
      reading_o <= query_valid_i ? read_d : reading_o;
      monitor_o <= (query_valid_i && query_i == ctlc_pkg::CTLC_Q_MON) ? mon_d : monitor_o;
      answer_valid_o <= query_valid_i;
    end
  end
endmodule

// file: verification/ctlc_host.sv
// host model issuing remote commands and queries
`timescale 1ns/10ps
module ctlc_host (
  input wire logic clk_i,
  output ctlc_pkg::ctlc_cmd_s cmd_o,
  output logic cmd_valid_o,
  output ctlc_pkg::ctlc_query_e query_o,
  output logic query_valid_o
);
  initial begin
    cmd_o = '0;
    cmd_valid_o = 1'b0;
    query_o = ctlc_pkg::CTLC_Q_CUR;
    query_valid_o = 1'b0;
  end
  // ==========
  // one command per call, value always present
  task automatic send(input ctlc_pkg::ctlc_cmd_e op, input logic [15:0] v, input logic f);
    @(negedge clk_i);
    cmd_o = '{op: op, value: v, flag: f};
    cmd_valid_o = 1'b1;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o.value <= ~v;
  endtask
  task automatic ask(input ctlc_pkg::ctlc_query_e q);
    @(negedge clk_i);
    query_o = q;
    query_valid_o = 1'b1;
    @(posedge clk_i);
    query_valid_o <= 1'b0;
  endtask
endmodule

// file: verification/ctlc_props.sv
// concurrent checks on the limit command block ports
`timescale 1ns/10ps
module ctlc_props #(
  parameter bit HIGH_CURRENT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ctlc_pkg::ctlc_cmd_s cmd_i,
  input wire logic cmd_valid_i,
  input wire logic query_valid_i,
  input wire ctlc_pkg::ctlc_meas_s meas_i,
  input wire logic [15:0] lower_limit_i,
  input wire logic lower_enable_i,
  input wire logic prog_running_i,
  input wire logic [2:0] screen_live_i,
  input wire logic [15:0] rup_o,
  input wire logic [15:0] vup_o,
  input wire logic resist_judge_o,
  input wire logic testing_o,
  input wire logic protect_o,
  input wire logic cmd_reject_o,
  input wire logic limit_order_warn_o,
  input wire logic [2:0] screen_o,
  input wire logic answer_valid_o
);
  // ==========
  // helpers
  logic [15:0] rmax;
  logic is_rup, is_vup, is_go;
  assign rmax = HIGH_CURRENT ? 16'h0258 : 16'h04B0;
  assign is_rup = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_RUP;
  assign is_vup = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_VUP;
  assign is_go = cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_BEGIN;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // assertions
  rup_take_a: assert property (is_rup && cmd_i.value inside {[16'h0001:rmax]}
    |=> rup_o == $past(cmd_i.value) && resist_judge_o) else $error("resistance limit not taken");
  rup_reject_a: assert property (is_rup && (cmd_i.value == 16'h0000 || cmd_i.value > rmax)
    |=> cmd_reject_o && $stable(rup_o)) else $error("bad resistance limit kept");
  vup_take_a: assert property (is_vup && cmd_i.value inside {[16'h0001:16'h021C]}
    |=> vup_o == $past(cmd_i.value) && !resist_judge_o) else $error("voltage limit not taken");
  stop_clears_a: assert property (cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_STOP
    && !(testing_o && $past(meas_i.over_power, 2)) |=> !testing_o && !protect_o)
    else $error("stop did not clear");
  begin_screen_a: assert property (is_go && !(screen_o inside {3'h0, 3'h1, 3'h4})
    && !prog_running_i && !testing_o |=> !testing_o) else $error("start on wrong screen");
  order_warn_a: assert property ((lower_enable_i && resist_judge_o && rup_o < lower_limit_i)
    [*3] |-> limit_order_warn_o) else $error("limit order warning missing");
  overload_a: assert property ($rose(meas_i.over_power) && testing_o
    |-> ##[1:5] (protect_o && !testing_o)) else $error("overload not protected");
  answer_a: assert property (query_valid_i |=> answer_valid_o) else $error("no answer");
  screen_sel_a: assert property (cmd_valid_i && cmd_i.op == ctlc_pkg::CTLC_CMD_SCREEN
    && cmd_i.value <= 16'h0004 |=> screen_o == $past(cmd_i.value[2:0])) else $error("screen");
  c_rup: cover property (is_rup ##1 resist_judge_o);
  c_prot: cover property (testing_o ##1 protect_o);
  c_warn: cover property (limit_order_warn_o);
endmodule
bind ctlc_top ctlc_props #(.HIGH_CURRENT(HIGH_CURRENT)) ctlc_props_inst (.clk_i, .rstn_i, .cmd_i,
  .cmd_valid_i, .query_valid_i, .meas_i, .lower_limit_i, .lower_enable_i, .prog_running_i,
  .screen_live_i, .rup_o, .vup_o, .resist_judge_o, .testing_o, .protect_o, .cmd_reject_o,
  .limit_order_warn_o, .screen_o, .answer_valid_o);

// file: verification/ctlc_top_tb.sv
// self-checking bench for the limit command block
`timescale 1ns/10ps
module ctlc_top_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  ctlc_pkg::ctlc_cmd_s cmd_i;
  logic cmd_valid_i, query_valid_i;
  ctlc_pkg::ctlc_query_e query_i;
  ctlc_pkg::ctlc_meas_s meas_i = '0;
  logic [15:0] test_current_i = 16'h0064, lower_limit_i = 16'h0000;
  logic lower_enable_i = 1'b0, max_mode_i = 1'b1, prog_running_i = 1'b0, prog_held_i = 1'b0;
  logic [2:0] screen_live_i = 3'h0;
  logic [2:0] screen_o;
  logic [15:0] rup_o, vup_o, test_time_o, reading_o;
  logic resist_judge_o, offset_en_o, timer_en_o, testing_o, protect_o, step_advance_o;
  logic cmd_reject_o, limit_order_warn_o, answer_valid_o, over_voltage_setting_error_o;
  logic over_rating_setting_error_o, over_resistance_setting_error_o;
  ctlc_pkg::ctlc_mon_s monitor_o;
  int failures = 0, n_checks = 0, m_rup = 1, m_vup = 60, m_tim = 10;
  logic m_rj = 1'b1, m_off = 1'b0, m_ten = 1'b0;
  int unsigned seed = 71439;
  int tv[7] = '{2, 3, 999, 1005, 1010, 9990, 9991};
  initial forever #50 clk_i = ~clk_i;
  ctlc_host host (.clk_i, .cmd_o(cmd_i), .cmd_valid_o(cmd_valid_i), .query_o(query_i),
    .query_valid_o(query_valid_i));
  ctlc_top #(.TICK_CYCLES(4)) ctlc_top_inst (.clk_i, .rstn_i, .cmd_i, .cmd_valid_i,
    .query_valid_i, .query_i, .meas_i, .test_current_i, .lower_limit_i, .lower_enable_i,
    .max_mode_i, .prog_running_i, .prog_held_i, .screen_live_i, .rup_o, .vup_o,
    .resist_judge_o, .offset_en_o, .test_time_o, .timer_en_o, .testing_o, .protect_o,
    .step_advance_o, .cmd_reject_o, .limit_order_warn_o, .over_voltage_setting_error_o,
    .over_rating_setting_error_o, .over_resistance_setting_error_o, .screen_o, .reading_o,
    .monitor_o, .answer_valid_o);
  // ==========
  // helpers
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed & 32'h7FFF);
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic model_cmp(input logic ok);
    chk(rup_o, 16'(m_rup));
    chk(vup_o, 16'(m_vup));
    chk(test_time_o, 16'(m_tim));
    chk({13'h0, resist_judge_o, timer_en_o, offset_en_o}, {13'h0, m_rj, m_ten, m_off});
    chk({15'h0, cmd_reject_o}, {15'h0, !ok});
  endtask
  task automatic send(input ctlc_pkg::ctlc_cmd_e op, input int v, input logic f);
    logic ok;
    ok = 1'b1;
    case (op)
      ctlc_pkg::CTLC_CMD_RUP: ok = v >= 1 && v <= 1200;
      ctlc_pkg::CTLC_CMD_VUP: ok = v >= 1 && v <= 540;
      ctlc_pkg::CTLC_CMD_TIME: ok = v >= 3 && v <= 9990 && (v < 1000 || v % 10 == 0);
      default: ok = 1'b1;
    endcase
    if (ok) begin
      case (op)
        ctlc_pkg::CTLC_CMD_RUP: {m_rup, m_rj} = {v, 1'b1};
        ctlc_pkg::CTLC_CMD_VUP: {m_vup, m_rj} = {v, 1'b0};
        ctlc_pkg::CTLC_CMD_TIME: {m_tim, m_ten} = {v, f};
        ctlc_pkg::CTLC_CMD_OFFS: m_off = f;
        ctlc_pkg::CTLC_CMD_RESISTANCE_JUDGMENT_SELECT: m_rj = f;
        ctlc_pkg::CTLC_CMD_VOLTAGE_JUDGMENT_SELECT: m_rj = !f;
        default: ;
      endcase
    end
    host.send(op, 16'(v), f);
    @(negedge clk_i);
    model_cmp(ok);
  endtask
  task automatic ask(input ctlc_pkg::ctlc_query_e q);
    host.ask(q);
    @(negedge clk_i);
    chk({15'h0, answer_valid_o}, 16'h0001);
  endtask
  task automatic start_chk(input logic e);
    repeat (3) @(negedge clk_i);
    send(ctlc_pkg::CTLC_CMD_BEGIN, 0, 1'b0);
    chk({15'h0, testing_o}, {15'h0, e});
    if (e) send(ctlc_pkg::CTLC_CMD_STOP, 0, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end
  // ==========
  // scenarios
  initial begin
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    model_cmp(1'b1);
    foreach (tv[i]) send(ctlc_pkg::CTLC_CMD_TIME, tv[i], i[0]);
    send(ctlc_pkg::CTLC_CMD_OFFS, 0, 1'b1);
    send(ctlc_pkg::CTLC_CMD_VOLTAGE_JUDGMENT_SELECT, 0, 1'b1);
    send(ctlc_pkg::CTLC_CMD_RESISTANCE_JUDGMENT_SELECT, 0, 1'b1);
    foreach (tv[i]) send(ctlc_pkg::CTLC_CMD_RUP, i < 4 ? i * 400 : rnd() % 1300, 1'b0);
    foreach (tv[i]) send(ctlc_pkg::CTLC_CMD_VUP, i < 4 ? i * 180 : rnd() % 600, 1'b0);
    send(ctlc_pkg::CTLC_CMD_RUP, 600, 1'b0);
    start_chk(1'b0);
    chk({15'h0, over_voltage_setting_error_o}, 16'h0001);
    test_current_i = 16'h0032;
    send(ctlc_pkg::CTLC_CMD_VUP, 540, 1'b0);
    start_chk(1'b0);
    chk({15'h0, over_resistance_setting_error_o}, 16'h0001);
    test_current_i = 16'h03E8;
    start_chk(1'b0);
    chk({15'h0, over_rating_setting_error_o}, 16'h0001);
    test_current_i = 16'h0064;
    send(ctlc_pkg::CTLC_CMD_VUP, 100, 1'b0);
    send(ctlc_pkg::CTLC_CMD_RUP, 100, 1'b0);
    {lower_enable_i, lower_limit_i} = {1'b1, 16'h01F4};
    start_chk(1'b0);
    chk({15'h0, limit_order_warn_o}, 16'h0001);
    lower_enable_i = 1'b0;
    screen_live_i = 3'h3;
    start_chk(1'b0);
    screen_live_i = 3'h4;
    start_chk(1'b1);
    {prog_running_i, prog_held_i} = 2'b11;
    send(ctlc_pkg::CTLC_CMD_BEGIN, 0, 1'b0);
    chk({15'h0, step_advance_o}, 16'h0001);
    {prog_running_i, prog_held_i} = 2'b00;
    for (int m = 0; m < 2; m++) begin
      send(ctlc_pkg::CTLC_CMD_RESISTANCE_JUDGMENT_SELECT, 0, m[0]);
      meas_i = '{cur: 16'h00FA, res: 16'h00B4, volt: 16'h01C2, over_power: 1'b0};
      start_chk(1'b0 + 1'b1);
      send(ctlc_pkg::CTLC_CMD_BEGIN, 0, 1'b0);
      repeat (4) @(negedge clk_i);
      ask(ctlc_pkg::CTLC_Q_MON);
      chk({14'h0, monitor_o.status[3:2]}, 16'h0003);
      chk(monitor_o.f1, m ? 16'h01C2 : 16'h00B4);
      chk(monitor_o.f2, 16'h00FA);
      chk(monitor_o.f3, m ? 16'h00B4 : 16'h01C2);
      chk(monitor_o.f4, m ? 16'h00B4 : 16'h01C2);
      // one 0.1 s tick has passed when the monitor is captured
      chk(monitor_o.f5, 16'(m_tim - 1));
      ask(m ? ctlc_pkg::CTLC_Q_RES : ctlc_pkg::CTLC_Q_VOLT);
      chk(reading_o, m ? 16'h00B4 : 16'h01C2);
      meas_i.over_power = 1'b1;
      repeat (6) @(negedge clk_i);
      chk({14'h0, protect_o, testing_o}, 16'h0002);
      meas_i = '0;
      send(ctlc_pkg::CTLC_CMD_STOP, 0, 1'b0);
      chk({14'h0, protect_o, testing_o}, 16'h0000);
      ask(ctlc_pkg::CTLC_Q_CUR);
      chk(reading_o, 16'h00FA);
    end
    // timed test: 3 ticks of 4 cycles, ends on the 12th edge
    send(ctlc_pkg::CTLC_CMD_TIME, 3, 1'b1);
    send(ctlc_pkg::CTLC_CMD_BEGIN, 0, 1'b0);
    repeat (11) @(negedge clk_i);
    chk({15'h0, testing_o}, 16'h0001);
    @(negedge clk_i);
    chk({15'h0, testing_o}, 16'h0000);
    ask(ctlc_pkg::CTLC_Q_TIME);
    chk(reading_o, 16'h0000);
    send(ctlc_pkg::CTLC_CMD_TIME, 3, 1'b0);
    ask(ctlc_pkg::CTLC_Q_TIME);
    chk(reading_o, 16'h0003);
    screen_live_i = 3'h6;
    repeat (3) @(negedge clk_i);
    chk({13'h0, screen_o}, 16'h0005);
    send(ctlc_pkg::CTLC_CMD_SCREEN, 2, 1'b0);
    chk({13'h0, screen_o}, 16'h0002);
    // no traffic follows the screen select
    tally_and_finish();
  end
endmodule
